// ===== common/ccr_consts.vh
// Offsets, field positions, reset values and step sizes for the clock
// output configuration registers. Definitions only.
`ifndef CCR_CONSTS_VH
`define CCR_CONSTS_VH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define CCR_CHAN_BASE 8'h24
`define CCR_CHAN_STRIDE 8'h08
`define CCR_PHASE_HI_OFS 8'h01
`define CCR_CHAN_CTRL_OFS 8'h02
`define CCR_OUT_ADDRS {8'h41, 8'h40, 8'h39, 8'h38, 8'h32, 8'h31, 8'h30, 8'h2a, 8'h29, 8'h28}
`define CCR_VCXO_OUT_ADDR 8'h4b
`define CCR_ENABLE_ADDR 8'h58

// ----------------------------------------
// Field positions
// ----------------------------------------
`define CCR_CHAN_PD_BIT 7
`define CCR_PHASE_LSB_BIT 0
`define CCR_EN_VCXO_BIT 5
`define CCR_EN_CHAN_TOP_BIT 4
`define CCR_OUT_PD_BIT 7
`define CCR_OUT_STYLE_BIT 4
`define CCR_VCXO_STYLE_LSB 4
`define CCR_AMP_LSB 2

// ----------------------------------------
// Writable masks and reset values
// ----------------------------------------
`define CCR_MASK_PHASE_HI 8'hff
`define CCR_MASK_CHAN_CTRL 8'h81
`define CCR_MASK_ENABLE 8'h3e
`define CCR_MASK_CLK_OUT 8'h9c
`define CCR_MASK_VCXO_OUT 8'hbc
`define CCR_RST_PHASE_HI 8'h00
`define CCR_RST_CHAN_CTRL 8'h00
`define CCR_RST_ENABLE 8'h00
`define CCR_RST_CLK_OUT 8'h04
`define CCR_RST_VCXO_OUT 8'h20

// ----------------------------------------
// Phase delay step per VCO, in ps
// ----------------------------------------
`define CCR_STEP_PS_VCO0 8'ha9
`define CCR_STEP_PS_VCO1 8'hcb

`endif

// ===== rtl/ccr_reg8.v
// One 8-bit configuration register with a writable-bit mask.
// Assumes a synchronous write strobe with address and data on the same edge.
`timescale 1ns/1ps
`include "ccr_consts.vh"

module ccr_reg8 #(
   parameter [7:0] ADDR = 8'h00,
   parameter [7:0] MASK = 8'hff,
   parameter [7:0] RST = 8'h00
) (
   // Clock and reset
   input wire clk_sys_in,
   input wire srst_in,
   // Register port
   input wire wr_en_in,
   input wire [7:0] addr_in,
   input wire [7:0] wdata_in,
   // Register state
   output wire hit_out,
   output wire [7:0] value_out
);

   reg [7:0] value_ff;

   assign hit_out = (addr_in == ADDR);
   assign value_out = value_ff;

   // ----------------------------------------
   // Storage
   // ----------------------------------------
   always @(posedge clk_sys_in) begin
      if (srst_in) begin
         value_ff <= RST;
      end else if (wr_en_in && hit_out) begin
         value_ff <= wdata_in & MASK;
      end
   end

endmodule // ccr_reg8

// ===== rtl/ccr_config_regs.v
// Configuration register bank for the clock channels and their outputs.
// Assumes a host bridge that presents single-cycle byte writes and reads
// synchronous to clk_sys_in; the VCO select comes from the synthesizer core.
//
// What this block does
// - With VCO 0 selected, a channel delays by its 9-bit phase setting times 169 ps, zero meaning no delay.
// - With VCO 1 selected, the same setting gives a delay of the setting times 203 ps.
// - A channel power-down bit set to 1 powers the whole channel down, defaulting to 0.
// - A channel enable of 0 holds all its outputs low, 1 enables them, default disabled; the VCXO output alike.
// - Each clock output has a power-down bit, 1 powering it down, default 0.
// - The VCXO output has its own power-down bit, default 0, 1 powering it down.
// - A clock output format bit selects LVDS at 0, the default, and LVPECL at 1.
// - The VCXO format selects LVDS at 00, LVPECL at 01, complementary LVCMOS at 1x, default 10.
// - A 2-bit amplitude picks 350, 500, 700 or 850 mV; clock outputs default 01, VCXO 00.
// - Channel power-down and phase LSB share a third channel register, the upper eight bits another.
// - The VCXO and four channel enables occupy bits 5 to 1 of one shared register.
`timescale 1ns/1ps
`include "ccr_consts.vh"

module ccr_config_regs #(
   parameter NUM_CHAN = 4,
   parameter NUM_OUT = 10
) (
   // Clock and reset
   input wire clk_sys_in,
   input wire srst_in,
   // Configuration port
   input wire wr_en_in,
   input wire rd_en_in,
   input wire [7:0] addr_in,
   input wire [7:0] wdata_in,
   output reg [7:0] rdata_out,
   output reg rd_valid_out,
   // Synthesizer state
   input wire vco1_select_in,
   // Channel controls
   output reg [9*NUM_CHAN-1:0] chan_phase_out,
   output reg [17*NUM_CHAN-1:0] chan_delay_ps_out,
   output reg [NUM_CHAN-1:0] channel_power_down_out,
   output reg [NUM_CHAN-1:0] chan_output_enable_out,
   // Clock output controls
   output reg [NUM_OUT-1:0] output_power_down_out,
   output reg [NUM_OUT-1:0] output_lvpecl_out,
   output reg [2*NUM_OUT-1:0] output_amplitude_out,
   output reg [NUM_OUT-1:0] channel_clock_output_active_out,
   // VCXO output controls
   output reg vcxo_output_enable_out,
   output reg vcxo_output_power_down_out,
   output reg vcxo_lvpecl_out,
   output reg vcxo_lvcmos_out,
   output reg [1:0] vcxo_amplitude_out,
   output reg vcxo_clock_output_active_out
);

   // ----------------------------------------
   // Register map layout
   // ----------------------------------------
   localparam NUM_REG = 2 * NUM_CHAN + NUM_OUT + 2;
   localparam IDX_OUT = 2 * NUM_CHAN;
   localparam IDX_VCXO = IDX_OUT + NUM_OUT;
   localparam IDX_EN = IDX_VCXO + 1;
   localparam [79:0] OUT_ADDRS = `CCR_OUT_ADDRS;
   // Channel owning each clock output: A0-A2, B0-B2, C0-C1, D0-D1
   localparam [19:0] OUT_CHAN = {2'd3, 2'd3, 2'd2, 2'd2, 2'd1, 2'd1, 2'd1, 2'd0, 2'd0, 2'd0};

   wire [NUM_REG-1:0] hit;
   wire [8*NUM_REG-1:0] vals;
   wire [7:0] en_reg;
   wire [7:0] vcxo_reg;

   assign en_reg = vals[8*IDX_EN +: 8];
   assign vcxo_reg = vals[8*IDX_VCXO +: 8];

   // ----------------------------------------
   // Channel registers
   // ----------------------------------------
   genvar gi;
   generate
      for (gi = 0; gi < NUM_CHAN; gi = gi + 1) begin : g_chan
         localparam [31:0] CH_BASE_W = `CCR_CHAN_BASE + gi * `CCR_CHAN_STRIDE;
         localparam [7:0] CH_BASE = CH_BASE_W[7:0];
         ccr_reg8 #(
            .ADDR(CH_BASE + `CCR_PHASE_HI_OFS),
            .MASK(`CCR_MASK_PHASE_HI),
            .RST(`CCR_RST_PHASE_HI)
         ) u_phase_hi (
            .clk_sys_in(clk_sys_in),
            .srst_in(srst_in),
            .wr_en_in(wr_en_in),
            .addr_in(addr_in),
            .wdata_in(wdata_in),
            .hit_out(hit[gi]),
            .value_out(vals[8*gi +: 8])
         );
         ccr_reg8 #(
            .ADDR(CH_BASE + `CCR_CHAN_CTRL_OFS),
            .MASK(`CCR_MASK_CHAN_CTRL),
            .RST(`CCR_RST_CHAN_CTRL)
         ) u_ctrl (
            .clk_sys_in(clk_sys_in),
            .srst_in(srst_in),
            .wr_en_in(wr_en_in),
            .addr_in(addr_in),
            .wdata_in(wdata_in),
            .hit_out(hit[NUM_CHAN + gi]),
            .value_out(vals[8*(NUM_CHAN + gi) +: 8])
         );
      end
   endgenerate

   // ----------------------------------------
   // Clock output registers
   // ----------------------------------------
   generate
      for (gi = 0; gi < NUM_OUT; gi = gi + 1) begin : g_out
         ccr_reg8 #(
            .ADDR(OUT_ADDRS[8*gi +: 8]),
            .MASK(`CCR_MASK_CLK_OUT),
            .RST(`CCR_RST_CLK_OUT)
         ) u_out (
            .clk_sys_in(clk_sys_in),
            .srst_in(srst_in),
            .wr_en_in(wr_en_in),
            .addr_in(addr_in),
            .wdata_in(wdata_in),
            .hit_out(hit[IDX_OUT + gi]),
            .value_out(vals[8*(IDX_OUT + gi) +: 8])
         );
      end
   endgenerate

   // ----------------------------------------
   // VCXO output and enable registers
   // ----------------------------------------
   // format default 10
   ccr_reg8 #(
      .ADDR(`CCR_VCXO_OUT_ADDR),
      .MASK(`CCR_MASK_VCXO_OUT),
      .RST(`CCR_RST_VCXO_OUT)
   ) u_vcxo (
      .clk_sys_in(clk_sys_in),
      .srst_in(srst_in),
      .wr_en_in(wr_en_in),
      .addr_in(addr_in),
      .wdata_in(wdata_in),
      .hit_out(hit[IDX_VCXO]),
      .value_out(vals[8*IDX_VCXO +: 8])
   );

   ccr_reg8 #(
      .ADDR(`CCR_ENABLE_ADDR),
      .MASK(`CCR_MASK_ENABLE),
      .RST(`CCR_RST_ENABLE)
   ) u_enable (
      .clk_sys_in(clk_sys_in),
      .srst_in(srst_in),
      .wr_en_in(wr_en_in),
      .addr_in(addr_in),
      .wdata_in(wdata_in),
      .hit_out(hit[IDX_EN]),
      .value_out(vals[8*IDX_EN +: 8])
   );

   // ----------------------------------------
   // Read-back
   // ----------------------------------------
   reg [7:0] nxt_rdata;
   integer ri;

   always @* begin
      nxt_rdata = 8'h00;
      for (ri = 0; ri < NUM_REG; ri = ri + 1) begin
         if (hit[ri]) begin
            nxt_rdata = nxt_rdata | vals[8*ri +: 8];
         end
      end
   end

   always @(posedge clk_sys_in) begin
      if (srst_in) begin
         rdata_out <= 8'h00;
         rd_valid_out <= 1'b0;
      end else begin
         rd_valid_out <= rd_en_in;
         if (rd_en_in) begin
            rdata_out <= nxt_rdata;
         end
      end
   end

   // ----------------------------------------
   // Channel control outputs
   // ----------------------------------------
   integer ci;

   always @(posedge clk_sys_in) begin
      if (srst_in) begin
         chan_phase_out <= {9*NUM_CHAN{1'b0}};
         chan_delay_ps_out <= {17*NUM_CHAN{1'b0}};
         channel_power_down_out <= {NUM_CHAN{1'b0}};
         chan_output_enable_out <= {NUM_CHAN{1'b0}};
      end else begin
         for (ci = 0; ci < NUM_CHAN; ci = ci + 1) begin
            chan_phase_out[9*ci +: 9] <= {vals[8*ci +: 8], vals[8*(NUM_CHAN + ci) + `CCR_PHASE_LSB_BIT]};
            chan_delay_ps_out[17*ci +: 17] <= {8'h00, vals[8*ci +: 8], vals[8*(NUM_CHAN + ci) + `CCR_PHASE_LSB_BIT]}
               * {9'h000, (vco1_select_in ? `CCR_STEP_PS_VCO1 : `CCR_STEP_PS_VCO0)};
            channel_power_down_out[ci] <= vals[8*(NUM_CHAN + ci) + `CCR_CHAN_PD_BIT];
            chan_output_enable_out[ci] <= en_reg[`CCR_EN_CHAN_TOP_BIT - ci];
         end
      end
   end

   // ----------------------------------------
   // Clock output controls
   // ----------------------------------------
   integer oi;

   always @(posedge clk_sys_in) begin
      if (srst_in) begin
         output_power_down_out <= {NUM_OUT{1'b0}};
         output_lvpecl_out <= {NUM_OUT{1'b0}};
         output_amplitude_out <= {NUM_OUT{2'b01}};
         channel_clock_output_active_out <= {NUM_OUT{1'b0}};
      end else begin
         for (oi = 0; oi < NUM_OUT; oi = oi + 1) begin
            output_power_down_out[oi] <= vals[8*(IDX_OUT + oi) + `CCR_OUT_PD_BIT];
            output_lvpecl_out[oi] <= vals[8*(IDX_OUT + oi) + `CCR_OUT_STYLE_BIT];
            output_amplitude_out[2*oi +: 2] <= vals[8*(IDX_OUT + oi) + `CCR_AMP_LSB +: 2];
            channel_clock_output_active_out[oi] <= en_reg[`CCR_EN_CHAN_TOP_BIT - OUT_CHAN[2*oi +: 2]]
               & ~vals[8*(NUM_CHAN + OUT_CHAN[2*oi +: 2]) + `CCR_CHAN_PD_BIT]
               & ~vals[8*(IDX_OUT + oi) + `CCR_OUT_PD_BIT];
         end
      end
   end

   // ----------------------------------------
   // VCXO output controls
   // ----------------------------------------
   always @(posedge clk_sys_in) begin
      if (srst_in) begin
         vcxo_output_enable_out <= 1'b0;
         vcxo_output_power_down_out <= 1'b0;
         vcxo_lvpecl_out <= 1'b0;
         vcxo_lvcmos_out <= 1'b1;
         vcxo_amplitude_out <= 2'b00;
         vcxo_clock_output_active_out <= 1'b0;
      end else begin
         vcxo_output_enable_out <= en_reg[`CCR_EN_VCXO_BIT];
         vcxo_output_power_down_out <= vcxo_reg[`CCR_OUT_PD_BIT];
         vcxo_lvpecl_out <= (vcxo_reg[`CCR_VCXO_STYLE_LSB +: 2] == 2'b01);
         vcxo_lvcmos_out <= vcxo_reg[`CCR_VCXO_STYLE_LSB + 1];
         vcxo_amplitude_out <= vcxo_reg[`CCR_AMP_LSB +: 2];
         vcxo_clock_output_active_out <= en_reg[`CCR_EN_VCXO_BIT] & ~vcxo_reg[`CCR_OUT_PD_BIT];
      end
   end

endmodule // ccr_config_regs

// ===== bench/ccr_host_model.sv
// Host model: byte writes and reads on the bank's register port.
// Assumes the bank samples requests on the rising edge of clk_sys_in.
`timescale 1ns/1ps

module ccr_host_model (
   // Clock and read return
   input wire logic clk_sys_in,
   input wire logic [7:0] rdata_in,
   input wire logic rd_valid_in,
   // Requests
   output logic wr_en_out,
   output logic rd_en_out,
   output logic [7:0] addr_out,
   output logic [7:0] wdata_out
);
   initial begin
      wr_en_out = 1'b0;
      rd_en_out = 1'b0;
      addr_out = 8'h00;
      wdata_out = 8'h00;
   end
   // Released lines show the inverse of the last value
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_sys_in);
      wr_en_out <= 1'b1;
      addr_out <= a;
      wdata_out <= d;
      @(posedge clk_sys_in);
      wr_en_out <= 1'b0;
      addr_out <= ~a;
      wdata_out <= ~d;
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic v);
      @(posedge clk_sys_in);
      rd_en_out <= 1'b1;
      addr_out <= a;
      @(posedge clk_sys_in);
      rd_en_out <= 1'b0;
      addr_out <= ~a;
      // Answer stands for the one cycle after the strobe
      #1;
      d = rdata_in;
      v = rd_valid_in;
      @(posedge clk_sys_in);
   endtask
endmodule // ccr_host_model

// ===== bench/ccr_config_regs_assertions.sv
// Checker for the configuration register bank, bound to its ports.
// Assumes requests and outputs are sampled on the rising edge of clk_sys_in.
`timescale 1ns/1ps

module ccr_config_regs_assertions #(
   parameter NUM_CHAN = 4,
   parameter NUM_OUT = 10
) (
   // Register port
   input wire logic clk_sys_in,
   input wire logic srst_in,
   input wire logic wr_en_in,
   input wire logic rd_en_in,
   input wire logic [7:0] addr_in,
   input wire logic [7:0] wdata_in,
   input wire logic [7:0] rdata_out,
   input wire logic vco1_select_in,
   // Controls
   input wire logic [9*NUM_CHAN-1:0] chan_phase_out,
   input wire logic [17*NUM_CHAN-1:0] chan_delay_ps_out,
   input wire logic [NUM_CHAN-1:0] channel_power_down_out,
   input wire logic [NUM_CHAN-1:0] chan_output_enable_out,
   input wire logic [NUM_OUT-1:0] output_power_down_out,
   input wire logic [NUM_OUT-1:0] output_lvpecl_out,
   input wire logic [2*NUM_OUT-1:0] output_amplitude_out,
   input wire logic [NUM_OUT-1:0] channel_clock_output_active_out,
   input wire logic vcxo_output_enable_out,
   input wire logic vcxo_output_power_down_out,
   input wire logic vcxo_lvpecl_out,
   input wire logic vcxo_lvcmos_out
);
   default clocking @(posedge clk_sys_in);
   endclocking
   default disable iff (srst_in);

   a_reserved_zero: assert property (rd_en_in && addr_in == 8'h58 |=> (rdata_out & 8'hc1) == 8'h00)
      else $error("reserved enable bits read nonzero");
   a_phase_upper: assert property (wr_en_in && addr_in == 8'h25 |-> ##2 chan_phase_out[8:1] == $past(wdata_in, 2))
      else $error("phase upper bits wrong");
   a_chan_ctrl: assert property (wr_en_in && addr_in == 8'h26 |-> ##2
      {channel_power_down_out[0], chan_phase_out[0]} == {$past(wdata_in[7], 2), $past(wdata_in[0], 2)})
      else $error("channel power-down or phase lsb wrong");
   a_delay_vco0: assert property (!$past(vco1_select_in) |->
      chan_delay_ps_out[16:0] == {8'h00, chan_phase_out[8:0]} * 17'd169) else $error("delay for vco 0 wrong");
   a_delay_vco1: assert property ($past(vco1_select_in) |->
      chan_delay_ps_out[67:51] == {8'h00, chan_phase_out[35:27]} * 17'd203) else $error("delay for vco 1 wrong");
   a_out_fields: assert property (wr_en_in && addr_in == 8'h28 |-> ##2
      {output_power_down_out[0], output_lvpecl_out[0], output_amplitude_out[1:0]} == {$past(wdata_in[7], 2),
      $past(wdata_in[4:2], 2)}) else $error("output fields wrong");
   a_vcxo_style: assert property (wr_en_in && addr_in == 8'h4b |-> ##2
      {vcxo_output_power_down_out, vcxo_lvcmos_out, vcxo_lvpecl_out} == {$past(wdata_in[7], 2),
      $past(wdata_in[5], 2), $past(wdata_in[5:4], 2) == 2'b01}) else $error("vcxo format wrong");
   a_enable_map: assert property (wr_en_in && addr_in == 8'h58 |-> ##2
      {vcxo_output_enable_out, chan_output_enable_out} == {$past(wdata_in[5], 2), $past(wdata_in[1], 2),
      $past(wdata_in[2], 2), $past(wdata_in[3], 2), $past(wdata_in[4], 2)}) else $error("enable bits misplaced");
   a_active_gate: assert property (channel_clock_output_active_out[9] ==
      (chan_output_enable_out[3] && !channel_power_down_out[3] && !output_power_down_out[9]))
      else $error("output active not gated");
   c_vcxo_write: cover property (wr_en_in && addr_in == 8'h4b);
   c_vco1_delay: cover property (vco1_select_in && chan_delay_ps_out[16:0] != 17'h0);
   c_active: cover property (channel_clock_output_active_out[9]);
endmodule // ccr_config_regs_assertions

bind ccr_config_regs ccr_config_regs_assertions #(.NUM_CHAN(NUM_CHAN), .NUM_OUT(NUM_OUT)) chk_u (.*);

// ===== bench/ccr_config_regs_tb.sv
// Testbench: the host model drives the bank; readback and control outputs are checked.
// Assumes the bank, the host model and the checker are compiled first.
`timescale 1ns/1ps

module ccr_config_regs_tb;
   logic clk_sys_in, srst_in, vco1_select_in, wr_en, rd_en, rd_valid, vv;
   logic ven, vpd, vlvpecl, vlvcmos, vact;
   logic [7:0] addr, wdata, rdata, rv;
   logic [1:0] vamp;
   logic [3:0] cpd, cen;
   logic [9:0] opd, lvpecl, act;
   logic [19:0] amp;
   logic [35:0] phase;
   logic [67:0] delay;
   int n_mismatch = 0;
   int checks_done = 0;
   logic [7:0] regs [0:23] = '{8'h28, 8'h29, 8'h2a, 8'h30, 8'h31, 8'h32, 8'h38, 8'h39, 8'h40, 8'h41, 8'h4b,
      8'h58, 8'h24, 8'h25, 8'h26, 8'h2c, 8'h2d, 8'h2e, 8'h34, 8'h35, 8'h36, 8'h3c, 8'h3d, 8'h3e};

   ccr_host_model host_u (.clk_sys_in(clk_sys_in), .rdata_in(rdata), .rd_valid_in(rd_valid), .wr_en_out(wr_en),
      .rd_en_out(rd_en), .addr_out(addr), .wdata_out(wdata));
   ccr_config_regs dut_u (.clk_sys_in(clk_sys_in), .srst_in(srst_in), .wr_en_in(wr_en), .rd_en_in(rd_en),
      .addr_in(addr), .wdata_in(wdata), .rdata_out(rdata), .rd_valid_out(rd_valid), .vco1_select_in(vco1_select_in),
      .chan_phase_out(phase), .chan_delay_ps_out(delay), .channel_power_down_out(cpd), .chan_output_enable_out(cen),
      .output_power_down_out(opd), .output_lvpecl_out(lvpecl), .output_amplitude_out(amp),
      .channel_clock_output_active_out(act), .vcxo_output_enable_out(ven), .vcxo_output_power_down_out(vpd),
      .vcxo_lvpecl_out(vlvpecl), .vcxo_lvcmos_out(vlvcmos), .vcxo_amplitude_out(vamp),
      .vcxo_clock_output_active_out(vact));

   function automatic logic [7:0] mask_of(input logic [7:0] a);
      if (a == 8'h4b) return 8'hbc;
      if (a == 8'h58) return 8'h3e;
      case (a[2:0])
         3'd4: return 8'h00;
         3'd5: return 8'hff;
         3'd6: return 8'h81;
         default: return 8'h9c;
      endcase
   endfunction
   function automatic logic [7:0] rst_of(input logic [7:0] a);
      if (a == 8'h4b) return 8'h20;
      return (a[2:0] < 3'd3 && a != 8'h58) ? 8'h04 : 8'h00;
   endfunction
   task automatic chk(input string what, input logic [67:0] exp, input logic [67:0] got);
      checks_done++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
      host_u.rd(a, rv, vv);
      chk("read valid", 68'(1), 68'(vv));
      chk($sformatf("reg %h", a), 68'(exp), 68'(rv));
   endtask
   task automatic settle;
      repeat (2) @(posedge clk_sys_in);
      #1;
   endtask
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", checks_done, n_mismatch);
      if (n_mismatch == 0 && checks_done > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask

   initial begin
      clk_sys_in = 1'b0;
      forever #2.5 clk_sys_in = ~clk_sys_in;
   end
   initial begin
      #100000;
      n_mismatch++;
      $display("watchdog expired");
      wrap_up();
   end
   initial begin
      srst_in = 1'b1;
      vco1_select_in = 1'b0;
      repeat (20) @(posedge clk_sys_in);
      srst_in <= 1'b0;
      foreach (regs[i]) rd_chk(regs[i], rst_of(regs[i]));
      rd_chk(8'h27, 8'h00);
      chk("amplitudes", 68'(20'h55555), 68'(amp));
      chk("vcxo defaults", 68'(7'h40), 68'({vlvcmos, vlvpecl, vpd, vamp, ven, vact}));
      chk("off state", 68'h0, 68'({opd, cpd, cen, act, lvpecl}));
      chk("zero phase", 68'h0, 68'(phase));
      chk("zero delay", 68'h0, delay);
      $display("test defaults done");
      foreach (regs[i]) host_u.wr(regs[i], 8'hff);
      foreach (regs[i]) rd_chk(regs[i], mask_of(regs[i]));
      chk("all set", 68'({66{1'b1}}), 68'({opd, lvpecl, cpd, cen, ven, vpd, phase}));
      chk("all gated", 68'h0, 68'({act, vact}));
      chk("amps set", 68'(20'hfffff), 68'(amp));
      chk("vcxo set", 68'(4'hb), 68'({vlvcmos, vlvpecl, vamp}));
      chk("delay vco 0", {4{17'd86359}}, delay);
      @(posedge clk_sys_in);
      vco1_select_in <= 1'b1;
      settle();
      chk("delay vco 1", {4{17'd103733}}, delay);
      $display("test fill done");
      host_u.wr(8'h25, 8'h00);
      host_u.wr(8'h26, 8'h01);
      host_u.wr(8'h3d, 8'h80);
      host_u.wr(8'h3e, 8'h00);
      host_u.wr(8'h28, 8'h00);
      host_u.wr(8'h41, 8'h00);
      settle();
      chk("phase", 68'({9'h100, 9'h1ff, 9'h1ff, 9'h001}), 68'(phase));
      chk("delays vco 1", {17'd51968, 17'd103733, 17'd103733, 17'd203}, delay);
      chk("active", 68'(10'h201), 68'(act));
      @(posedge clk_sys_in);
      vco1_select_in <= 1'b0;
      settle();
      chk("delays vco 0", {17'd43264, 17'd86359, 17'd86359, 17'd169}, delay);
      $display("test phase done");
      for (int s = 0; s < 4; s++) begin
         host_u.wr(8'h4b, {2'b00, s[1:0], s[1:0], 2'b00});
         host_u.wr(8'h28, {3'b000, s[0], s[1:0], 2'b00});
         settle();
         chk("vcxo fields", 68'({1'b0, s[1], s == 1, s[1:0], 1'b1}), 68'({vpd, vlvcmos, vlvpecl, vamp, vact}));
         chk("out0 fields", 68'({s[0], s[1:0]}), 68'({lvpecl[0], amp[1:0]}));
      end
      $display("test formats done");
      host_u.wr(8'h58, 8'h20);
      settle();
      chk("enables", 68'(16'hc000), 68'({vact, ven, cen, act}));
      rd_chk(8'h58, 8'h20);
      $display("test enables done");
      wrap_up();
   end
endmodule // ccr_config_regs_tb
